/* File: hw/sar_converter_sequencer.sv */
// control logic and register file of the successive approximation converter
//
// Functional notes
// (RULE1) control bit 7 powers the converter when one, removes power when zero
// (RULE2) writing one to the trigger bit starts one conversion; zero does nothing
// (RULE3) software must not write control again until the done flag is set
// (RULE4) slow select zero gives 2MHz sampling clock, one gives 333kHz
// (RULE5) conversion clock stays at 2MHz regardless of slow select
// (RULE6) each conversion runs 6 sampling then 14 conversion clocks
// (RULE7) setting the trigger clears the done flag in hardware
// (RULE8) finishing a conversion sets the done flag in hardware
// (RULE9) done flag is the interrupt request; software clears it, hardware sets it
// (RULE10) 12-bit result, 11 selectable channels sharing pins with general I/O
// (RULE11) one channel is an internal quarter-supply tap for supply measurement
// (RULE12) select 0-9 external channels, 10-14 reserved, 15 quarter supply
// (RULE13) result bits 11:4 in high byte, bits 3:0 in low byte bits 7:4
// (RULE14) interrupt enable bit gates the done flag onto the interrupt
// (RULE15) done flag in bit 4, input select in bits 3:0
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module sar_converter_sequencer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // interrupts
    output logic converter_irq,
    output logic event_irq,
    // analogue core
    input wire logic comparator_in,
    output logic converter_power_on,
    output logic [3:0] input_channel_select,
    output logic quarter_supply_tap_en,
    output logic [sar_seq_pkg::EXT_CHANNELS-1:0] analog_channel_pin,
    output logic sample_hold,
    output logic [sar_seq_pkg::RESULT_BITS-1:0] dac_code,
    output logic busy
);
    import sar_seq_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // clock ticks

    logic run;
    logic fast_tick;
    logic slow_tick;
    logic sample_tick;
    logic slow_latched;

    tick_divider #(.DIV(FAST_DIV)) u_fast_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(run),
        .tick(fast_tick)
    );

    tick_divider #(.DIV(SLOW_DIV)) u_slow_tick (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .run(run),
        .tick(slow_tick)
    );

    // sampling speed follows the bit latched at trigger time
    assign sample_tick = slow_latched ? slow_tick : fast_tick; // [RULE4]

    ////////////////////////////////////////////////////////////////////////////
    // comparator synchroniser

    logic cmp_meta;
    logic cmp_sync;

    // comparator is asynchronous to clk_sys
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= comparator_in;
            cmp_sync <= cmp_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register access decode

    logic wr_control;
    logic wr_irq_enable;
    logic wr_mask;
    logic rd_status;
    logic start;
    logic finish;

    assign wr_control = reg_wr && (reg_addr == ADDR_CONTROL);
    assign wr_irq_enable = reg_wr && (reg_addr == ADDR_IRQ_ENABLE);
    assign wr_mask = reg_wr && (reg_addr == ADDR_EVENT_MASK);
    assign rd_status = reg_rd && (reg_addr == ADDR_EVENT_STATUS);
    // a trigger needs power; writes while busy are refused
    assign start = wr_control && !busy && reg_wdata[BIT_TRIGGER]
                   && reg_wdata[BIT_POWER_ON]; // [RULE2]

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    seq_state_t state;
    seq_state_t next_state;
    logic [4:0] step;
    logic [4:0] next_step;
    logic [11:0] next_dac;
    logic next_slow;
    logic [3:0] bit_idx;

    assign run = (state != SEQ_IDLE);
    assign bit_idx = 4'(RESULT_BITS - int'(step));
    assign finish = (state == SEQ_CONVERT) && fast_tick
                    && (step == 5'(CONVERT_CLOCKS - 1));

    // step counts ticks within each phase; trial bit walks msb to lsb
    always_comb begin
        next_state = state;
        next_step = step;
        next_dac = dac_code;
        next_slow = slow_latched;
        case (state)
            SEQ_IDLE: begin
                if (start) begin
                    next_state = SEQ_SAMPLE;
                    next_step = '0;
                    next_slow = reg_wdata[BIT_SLOW_SELECT];
                    next_dac = DAC_MIDSCALE;
                end
            end
            SEQ_SAMPLE: begin
                if (sample_tick) begin
                    if (step == 5'(SAMPLE_CLOCKS - 1)) begin // [RULE6]
                        next_state = SEQ_CONVERT;
                        next_step = '0;
                    end else begin
                        next_step = step + 1'b1;
                    end
                end
            end
            SEQ_CONVERT: begin
                // conversion clock always the fast divider
                if (fast_tick) begin // [RULE5]
                    if (finish) begin // [RULE6]
                        next_state = SEQ_IDLE;
                        next_step = '0;
                    end else begin
                        next_step = step + 1'b1;
                        // step 0 settles midscale, steps 1..12 decide one bit each
                        if (step != '0 && step <= 5'(RESULT_BITS)) begin // [RULE10]
                            if (!cmp_sync) begin
                                next_dac[bit_idx] = 1'b0;
                            end
                            if (bit_idx != '0) begin
                                next_dac[bit_idx - 1'b1] = 1'b1;
                            end
                        end
                    end
                end
            end
            default: begin
                next_state = SEQ_IDLE;
            end
        endcase
        // power loss aborts a conversion in flight
        if (!converter_power_on && state != SEQ_IDLE) begin // [RULE1]
            next_state = SEQ_IDLE;
            next_step = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state <= SEQ_IDLE;
            step <= '0;
            dac_code <= RESULT_RESET;
            slow_latched <= 1'b0;
        end else begin
            state <= next_state;
            step <= next_step;
            dac_code <= next_dac;
            slow_latched <= next_slow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control, result and interrupt registers

    control_t ctrl;
    control_t next_ctrl;
    logic [11:0] result;
    logic [11:0] next_result;
    logic irq_enable;
    logic next_irq_enable;
    logic [EVENT_BITS-1:0] status;
    logic [EVENT_BITS-1:0] next_status;
    logic [EVENT_BITS-1:0] mask;
    logic [EVENT_BITS-1:0] next_mask;
    logic [EVENT_BITS-1:0] events;

    assign events[EVT_DONE] = finish;
    assign events[EVT_WRITE_BUSY] = wr_control && busy;

    always_comb begin
        next_ctrl = ctrl;
        next_result = result;
        next_irq_enable = irq_enable;
        next_mask = mask;
        // trigger never stores; it reads back as zero
        next_ctrl.conversion_trigger = 1'b0; // [RULE2]
        if (wr_control && !busy) begin // [RULE3]
            next_ctrl.converter_power_on = reg_wdata[BIT_POWER_ON]; // [RULE1]
            next_ctrl.slow_sample_clock_select = reg_wdata[BIT_SLOW_SELECT];
            next_ctrl.input_channel_select = reg_wdata[3:0]; // [RULE15]
            // software may only clear the flag; hardware sets it
            next_ctrl.conversion_done_flag = ctrl.conversion_done_flag
                                             & reg_wdata[BIT_DONE]; // [RULE9]
            if (start) begin
                next_ctrl.conversion_done_flag = 1'b0; // [RULE7]
            end
        end
        // completion wins over a clearing write in the same cycle
        if (finish) begin
            next_ctrl.conversion_done_flag = 1'b1; // [RULE8]
            next_result = dac_code;
        end
        if (wr_irq_enable) begin
            next_irq_enable = reg_wdata[BIT_IRQ_ENABLE];
        end
        if (wr_mask) begin
            next_mask = reg_wdata[EVENT_BITS-1:0];
        end
        // read clears, but a new event in the same cycle survives
        next_status = (rd_status ? '0 : status) | events;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl <= control_t'(CONTROL_RESET);
            result <= RESULT_RESET;
            irq_enable <= 1'b0;
            mask <= '0;
            status <= '0;
        end else begin
            ctrl <= next_ctrl;
            result <= next_result;
            irq_enable <= next_irq_enable;
            mask <= next_mask;
            status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and registered outputs

    logic [7:0] next_rdata;
    logic [EXT_CHANNELS-1:0] next_pins;
    logic next_tap;

    // unmapped addresses read as zero
    always_comb begin
        next_rdata = 8'h00;
        if (!reg_rd) begin
            next_rdata = 8'h00;
        end else if (reg_addr == ADDR_CONTROL) begin
            next_rdata = ctrl; // [RULE15]
        end else if (reg_addr == ADDR_RESULT_HIGH) begin
            next_rdata = result[11:4]; // [RULE13]
        end else if (reg_addr == ADDR_RESULT_LOW) begin
            next_rdata = {result[3:0], 4'h0}; // [RULE13]
        end else if (reg_addr == ADDR_IRQ_ENABLE) begin
            next_rdata = 8'(irq_enable) << BIT_IRQ_ENABLE;
        end else if (reg_addr == ADDR_EVENT_STATUS) begin
            next_rdata = 8'(status);
        end else if (reg_addr == ADDR_EVENT_MASK) begin
            next_rdata = 8'(mask);
        end
    end

    // pin handover to the converter only while powered; reserved codes pick nothing
    always_comb begin
        next_pins = '0;
        next_tap = 1'b0;
        if (next_ctrl.converter_power_on) begin
            if (next_ctrl.input_channel_select <= SEL_LAST_EXTERNAL) begin // [RULE12]
                next_pins[next_ctrl.input_channel_select] = 1'b1; // [RULE10]
            end else if (next_ctrl.input_channel_select == SEL_QUARTER_SUPPLY) begin
                next_tap = 1'b1; // [RULE11]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
            converter_irq <= 1'b0;
            event_irq <= 1'b0;
            converter_power_on <= 1'b0;
            input_channel_select <= 4'h0;
            quarter_supply_tap_en <= 1'b0;
            analog_channel_pin <= '0;
            sample_hold <= 1'b0;
            busy <= 1'b0;
        end else begin
            reg_rdata <= next_rdata;
            converter_irq <= next_ctrl.conversion_done_flag & next_irq_enable; // [RULE14]
            event_irq <= |(next_status & next_mask);
            converter_power_on <= next_ctrl.converter_power_on; // [RULE1]
            input_channel_select <= next_ctrl.input_channel_select;
            quarter_supply_tap_en <= next_tap;
            analog_channel_pin <= next_pins;
            sample_hold <= (next_state == SEQ_SAMPLE);
            busy <= (next_state != SEQ_IDLE);
        end
    end

endmodule // sar_converter_sequencer
`default_nettype wire

/* File: hw/sar_seq_pkg.sv */
// constants, register map and types for the converter sequencer
package sar_seq_pkg;

    // clock rates and derived divider counts
    localparam int SYS_CLK_HZ = 40_000_000;
    localparam int FAST_CLK_HZ = 2_000_000;
    localparam int SLOW_CLK_HZ = 333_000;
    localparam int FAST_DIV = SYS_CLK_HZ / FAST_CLK_HZ;
    localparam int SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;

    // conversion sequence lengths in converter clocks, result width and external channel count
    localparam int SAMPLE_CLOCKS = 6;
    localparam int CONVERT_CLOCKS = 14;
    localparam int RESULT_BITS = 12;
    localparam int EXT_CHANNELS = 10;

    // register offsets
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_CONTROL = 8'had;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hae;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'haf;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'hb0;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'hb1;

    // field positions and event register width
    localparam int BIT_POWER_ON = 7;
    localparam int BIT_TRIGGER = 6;
    localparam int BIT_SLOW_SELECT = 5;
    localparam int BIT_DONE = 4;
    localparam int BIT_IRQ_ENABLE = 6;
    localparam int EVT_DONE = 0;
    localparam int EVT_WRITE_BUSY = 1;
    localparam int EVENT_BITS = 2;

    // select codes
    localparam logic [3:0] SEL_LAST_EXTERNAL = 4'h9;
    localparam logic [3:0] SEL_QUARTER_SUPPLY = 4'hf;

    // reset values and the midscale trial code loaded at conversion start
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    localparam logic [11:0] DAC_MIDSCALE = 12'h800;

    typedef struct packed {
        logic converter_power_on;
        logic conversion_trigger;
        logic slow_sample_clock_select;
        logic conversion_done_flag;
        logic [3:0] input_channel_select;
    } control_t;

    typedef enum {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} seq_state_t;

endpackage

/* File: hw/tick_divider.sv */
// clock enable pulse generator dividing the system clock
`timescale 1ns/10ps
`default_nettype none
module tick_divider #(
    parameter int DIV = 20
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // control and pulse
    input wire logic run,
    output logic tick
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_tick;

    // restart phase whenever run drops so every conversion starts aligned
    always_comb begin
        next_count = '0;
        next_tick = 1'b0;
        if (run) begin
            if (count == LAST) begin
                next_tick = 1'b1;
            end else begin
                next_count = count + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule // tick_divider
`default_nettype wire

/* File: verif/sar_seq_monitor.sv */
// port-level checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sar_seq_monitor import sar_seq_pkg::*; (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // core side
    input wire logic converter_irq,
    input wire logic converter_power_on,
    input wire logic [3:0] input_channel_select,
    input wire logic quarter_supply_tap_en,
    input wire logic [sar_seq_pkg::EXT_CHANNELS-1:0] analog_channel_pin,
    input wire logic sample_hold,
    input wire logic busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic ctl_wr;
    logic slow, next_slow, irq_en, next_irq_en;
    logic [11:0] samp, next_samp, conv, next_conv;
    // a control write while busy is refused, so only idle writes count
    assign ctl_wr = reg_wr && (reg_addr == ADDR_CONTROL) && !busy;
    // shadow state and phase lengths in system clocks
    always_comb begin
        next_slow = ctl_wr ? reg_wdata[BIT_SLOW_SELECT] : slow;
        next_irq_en = (reg_wr && reg_addr == ADDR_IRQ_ENABLE) ? reg_wdata[BIT_IRQ_ENABLE] : irq_en;
        next_samp = sample_hold ? samp + 12'h001 : 12'h000;
        next_conv = (busy && !sample_hold) ? conv + 12'h001 : 12'h000;
    end
    // shadow registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            slow <= 1'b0;
            irq_en <= 1'b0;
            samp <= 12'h000;
            conv <= 12'h000;
        end else begin
            slow <= next_slow;
            irq_en <= next_irq_en;
            samp <= next_samp;
            conv <= next_conv;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_power_follows: assert property (
        ctl_wr |=> converter_power_on == $past(reg_wdata[BIT_POWER_ON]))
        else $error("power bit did not follow the control write");
    a_trigger_starts: assert property (
        ctl_wr && reg_wdata[BIT_POWER_ON] && reg_wdata[BIT_TRIGGER]
        |=> busy && sample_hold)
        else $error("trigger did not start sampling");
    a_no_start: assert property (
        ctl_wr && !(reg_wdata[BIT_POWER_ON] && reg_wdata[BIT_TRIGGER]) |=> !busy)
        else $error("conversion started without a powered trigger");
    a_select_follows: assert property (
        ctl_wr |=> input_channel_select == $past(reg_wdata[3:0]))
        else $error("select field did not follow the control write");
    a_tap_decode: assert property (
        busy && $past(busy)
        |-> quarter_supply_tap_en == (input_channel_select == SEL_QUARTER_SUPPLY))
        else $error("quarter supply tap decode wrong");
    a_pin_decode: assert property (
        busy && $past(busy)
        |-> analog_channel_pin == ((input_channel_select <= SEL_LAST_EXTERNAL)
        ? (10'h001 << input_channel_select) : 10'h000))
        else $error("channel pin decode wrong");
    a_sample_length: assert property (
        $fell(sample_hold)
        |-> samp >= 5 * (slow ? SLOW_DIV : FAST_DIV)
        && samp <= 6 * (slow ? SLOW_DIV : FAST_DIV) + 4)
        else $error("sampling phase length wrong");
    a_convert_length: assert property (
        $fell(busy) |-> conv >= 13 * FAST_DIV && conv <= 14 * FAST_DIV + 8)
        else $error("conversion phase length wrong");
    a_irq_gated: assert property (
        !irq_en && !$past(irq_en) |-> !converter_irq)
        else $error("interrupt raised while disabled");
    a_refused_write: assert property (
        busy && reg_wr && reg_addr == ADDR_CONTROL
        |=> converter_power_on == $past(converter_power_on))
        else $error("control write taken while busy");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside the answer cycle");
endmodule // sar_seq_monitor
bind sar_converter_sequencer sar_seq_monitor sar_seq_monitor_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .converter_irq(converter_irq),
    .converter_power_on(converter_power_on), .input_channel_select(input_channel_select),
    .quarter_supply_tap_en(quarter_supply_tap_en), .analog_channel_pin(analog_channel_pin),
    .sample_hold(sample_hold), .busy(busy));
`default_nettype wire

/* File: verif/sar_core_model.sv */
// behavioural analogue core: input routing and comparator
`timescale 1ns/10ps
`default_nettype none
module sar_core_model (
    // input level and core controls
    input wire logic [sar_seq_pkg::RESULT_BITS-1:0] level,
    input wire logic [sar_seq_pkg::RESULT_BITS-1:0] dac_code,
    input wire logic [sar_seq_pkg::EXT_CHANNELS-1:0] analog_channel_pin,
    input wire logic quarter_supply_tap_en,
    input wire logic converter_power_on,
    // comparator decision
    output logic comparator_in
);
    import sar_seq_pkg::*;
    logic routed;
    // a reserved code routes nothing, so the comparator never trips and the result is zero
    assign routed = converter_power_on && ((analog_channel_pin != '0) || quarter_supply_tap_en);
    // ideal comparator: high when the input is at or above the trial code
    assign comparator_in = routed && (level >= dac_code);
endmodule // sar_core_model
`default_nettype wire

/* File: verif/test_sar_converter_sequencer.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module test_sar_converter_sequencer;
    import sar_seq_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, got;
    logic converter_irq, event_irq, comparator_in, converter_power_on, quarter_supply_tap_en;
    logic sample_hold, busy;
    logic [3:0] input_channel_select;
    logic [EXT_CHANNELS-1:0] analog_channel_pin;
    logic [RESULT_BITS-1:0] dac_code, e;
    logic [11:0] level = 12'h000;
    logic [15:0] seed = 16'he425;
    int failures = 0;
    int checks_done = 0;
    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;
    sar_converter_sequencer sar_converter_sequencer_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .converter_irq(converter_irq), .event_irq(event_irq),
        .comparator_in(comparator_in), .converter_power_on(converter_power_on),
        .input_channel_select(input_channel_select),
        .quarter_supply_tap_en(quarter_supply_tap_en), .analog_channel_pin(analog_channel_pin),
        .sample_hold(sample_hold), .dac_code(dac_code), .busy(busy));
    sar_core_model sar_core_model_inst (.level(level), .dac_code(dac_code),
        .analog_channel_pin(analog_channel_pin), .quarter_supply_tap_en(quarter_supply_tap_en),
        .converter_power_on(converter_power_on), .comparator_in(comparator_in));
    ////////////////////////////////////////////////////////////////////////////////
    // pseudo-random source, repeatable from its fixed start value
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // control readback: trigger always reads as zero
    function automatic logic [7:0] exp_ctrl(input logic slow, input logic [3:0] sel,
                                            input logic done);
        return {1'b1, 1'b0, slow, done, sel};
    endfunction
    // only external channels and the tap carry a level
    function automatic logic [11:0] exp_level(input logic [3:0] sel, input logic [11:0] lvl);
        return (sel <= SEL_LAST_EXTERNAL || sel == SEL_QUARTER_SUPPLY) ? lvl : 12'h000;
    endfunction
    task automatic check(input string what, input logic [11:0] exp, input logic [11:0] seen);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one-cycle write; the trailing delay lets the taken edge settle before sampling
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    // one-cycle read; data stand only in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        got = reg_rdata;
    endtask
    task automatic wait_idle();
        int n;
        for (n = 0; n < 2000 && busy !== 1'b0; n++) begin
            @(posedge clk_sys);
            #1;
        end
        if (n == 2000) begin
            failures++;
            $display("ERROR busy expected 0 seen %0h", busy);
            wrap_up();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (2) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rd(ADDR_CONTROL);
        check("control reset", {4'h0, CONTROL_RESET}, got);
        rd(ADDR_RESULT_HIGH);
        check("result reset", 12'h000, got);
        rd(8'h10);
        check("unmapped read", 12'h000, got);
        wr(ADDR_CONTROL, 8'h4f);
        check("unpowered trigger", 12'h000, busy);
        wr(ADDR_EVENT_MASK, 8'h03);
        rd(ADDR_EVENT_MASK);
        check("mask readback", 12'h003, got);
        // every select code, random level, speed and interrupt enable
        for (int sel = 0; sel < 16; sel++) begin
            seed = lfsr_next(seed);
            level <= seed[11:0];
            e = exp_level(sel[3:0], seed[11:0]);
            wr(ADDR_IRQ_ENABLE, {1'b0, seed[13], 6'h00});
            // odd codes left the flag set last round, so this trigger must clear it
            wr(ADDR_CONTROL, {2'b11, seed[12], 1'b0, sel[3:0]});
            rd(ADDR_CONTROL);
            check("done cleared", exp_ctrl(seed[12], sel[3:0], 1'b0), got);
            if (sel == 3) begin
                wr(ADDR_CONTROL, 8'h00);
                check("busy write refused", 12'h001, busy);
            end
            wait_idle();
            repeat (3) @(posedge clk_sys);
            #1;
            check("irq level", seed[13], converter_irq);
            rd(ADDR_CONTROL);
            check("done set", exp_ctrl(seed[12], sel[3:0], 1'b1), got);
            rd(ADDR_RESULT_HIGH);
            check("result high", {4'h0, e[11:4]}, got);
            rd(ADDR_RESULT_LOW);
            check("result low", {4'h0, e[3:0], 4'h0}, got);
            // even codes clear the flag, odd codes write one and keep it; no trigger
            wr(ADDR_CONTROL, {3'b100, sel[0], sel[3:0]});
            check("no start", 12'h000, busy);
            rd(ADDR_CONTROL);
            check("done after clear", exp_ctrl(1'b0, sel[3:0], sel[0]), got);
            repeat (3) @(posedge clk_sys);
            #1;
            check("irq after clear", sel[0] & seed[13], converter_irq);
        end
        // sticky events, read to clear
        check("event irq set", 12'h001, event_irq);
        rd(ADDR_EVENT_STATUS);
        check("event status", 12'h003, got);
        repeat (2) @(posedge clk_sys);
        #1;
        check("event irq clear", 12'h000, event_irq);
        rd(ADDR_EVENT_STATUS);
        check("status cleared", 12'h000, got);
        // result bytes belong to the converter; bus writes to them are dropped
        wr(ADDR_RESULT_HIGH, 8'h5a);
        rd(ADDR_RESULT_HIGH);
        check("result write ignored", {4'h0, e[11:4]}, got);
        wrap_up();
    end
endmodule // test_sar_converter_sequencer
`default_nettype wire
